/* inc/asx_pkg.sv */
// package for the asynchronous x16 sram host controller
// assumes a 10 MHz core clock; all pin timing is counted in core clock cycles
package asx_pkg;
    // core clock period in ns
    localparam int unsigned CLK_PERIOD_NS = 100;
    // power-up wait before the first access, in us
    localparam int unsigned POWERUP_WAIT_US = 200;
    // power-up wait in cycles, least time rounded up
    localparam int unsigned POWERUP_CYCLES =
        (POWERUP_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // read cycle time in ns, also the recovery after retention
    localparam int unsigned READ_CYCLE_NS = 45;
    localparam int unsigned READ_CYCLE_CYCLES =
        (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // write strobe low time in ns (least), counted in cycles
    localparam int unsigned WRITE_PULSE_NS = 35;
    localparam int unsigned WRITE_PULSE_CYCLES =
        (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // deselect to retention delay in ns; zero, so no wait state is needed
    localparam int unsigned DESELECT_TO_RETENTION_NS = 0;
    // pin widths and the wait timer width
    localparam int unsigned ADDR_W = 20;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned WAIT_W = 12;
    // width-select strap levels
    localparam logic WIDTH_X16 = 1'b1;
    localparam logic WIDTH_X8  = 1'b0;
    // controller states
    typedef enum logic [2:0] {
        ASX_POWERUP,
        ASX_IDLE,
        ASX_READ,
        ASX_WRITE,
        ASX_RETAIN,
        ASX_RECOVER
    } asx_state_t;
endpackage

/* hdl/asx_wait_timer.sv */
// down counter used for every timed wait of the sram host controller
// assumes load and count come from logic on the same clock
`timescale 1ns/10ps
module asx_wait_timer (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        load,      // load a new count
    input  wire logic [11:0] loadValue, // cycles to wait
    output logic             done       // count has reached zero
);
    logic [11:0] count_q;  // remaining cycles
    logic [11:0] count_d;

    // next count: load wins, otherwise step down to zero
    always_comb begin
        count_d = count_q;
        if (load) begin
            count_d = loadValue;
        end else if (count_q != 12'h000) begin
            count_d = count_q - 12'h001;
        end
    end

    // register only
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 12'h000;
        end else begin
            count_q <= count_d;
        end
    end

    assign done = (count_q == 12'h000) && !load;
endmodule

/* hdl/asx_host_ctrl.sv */
// host controller that drives an asynchronous 512K x16 sram through its pins
// assumes one request at a time from logic on core_clk; sram data pins arrive async
// What this block does
// - write: selects active, write strobe low, lanes
// - read: selects active, output strobe low
// - width strap picks x16 or x8 mode
// - retention deselects through selects and lanes
// - retention may start right at deselect
// - no access before 200 us power-up wait
`timescale 1ns/10ps
module asx_host_ctrl (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        reqValid,           // request strobe, one cycle
    input  wire logic        reqWrite,           // 1 write, 0 read
    input  wire logic [19:0] reqAddr,            // word address, or byte address in x8
    input  wire logic [1:0]  reqLaneEn,          // bit0 low lane, bit1 high lane
    input  wire logic [15:0] reqWData,           // write data
    input  wire logic        retainReq,          // level: hold memory in retention
    input  wire logic        widthSelect,        // strap: 1 x16, 0 x8
    output logic             reqReady,           // may take a request
    output logic             rspValid,           // read data pulse
    output logic [15:0]      rspRData,           // read data
    output logic             inRetention,        // memory deselected for retention
    output logic [18:0]      sramAddr,           // address pins
    output logic             extra_address_bit,  // top address bit in x8 mode
    output logic             select_active_low,
    output logic             select_active_high,
    output logic             writeStrobe_n,
    output logic             outputStrobe_n,
    output logic             upper_lane_enable_n,
    output logic             lower_lane_enable_n,
    output logic [15:0]      sramDataOut,
    output logic [15:0]      sramDataOe,         // high while host drives the bit
    input  wire logic [15:0] sramDataIn
);
    asx_pkg::asx_state_t state_q, state_d;       // controller state
    logic        done;                           // timer expired
    logic        tLoad;                          // timer load strobe
    logic [11:0] tValue;                         // timer load value
    logic [15:0] dSync1_q, dSync2_q;             // data pin synchroniser
    logic        strap_q, strap_d;               // width strap sampled after reset
    logic        reqReady_q, reqReady_d;
    logic        rspValid_q, rspValid_d;
    logic [15:0] rspRData_q, rspRData_d;
    logic [18:0] addr_q, addr_d;
    logic        a19_q, a19_d;
    logic        selN_q, selN_d, selH_q, selH_d;
    logic        weN_q, weN_d, oeN_q, oeN_d;
    logic        ubN_q, ubN_d, lbN_q, lbN_d;
    logic [15:0] dOut_q, dOut_d, dOe_q, dOe_d;
    logic        retain_q, retain_d;
    logic [1:0]  lanes_q, lanes_d;               // lanes of the access in flight
    logic        puLoad_q;                       // one-shot after reset, starts the power-up count

    // timer shares all waits, keeps the main file free of counters
    asx_wait_timer u_timer (
        .core_clk  (core_clk),
        .rst_n     (rst_n),
        .load      (tLoad),
        .loadValue (tValue),
        .done      (done)
    );

    // lane enable pin pair for a request; in x8 mode lanes are unused and held low
    function automatic logic [1:0] laneEnN(input logic [1:0] en, input logic x16);
        laneEnN = x16 ? ~en : 2'b00;
    endfunction

    // next state of the bus sequencer
    always_comb begin
        state_d = state_q;
        strap_d = strap_q;
        reqReady_d = 1'b0;
        rspValid_d = 1'b0;
        rspRData_d = rspRData_q;
        addr_d = addr_q;
        a19_d = a19_q;
        selN_d = selN_q;
        selH_d = selH_q;
        weN_d = 1'b1;
        oeN_d = 1'b1;
        ubN_d = ubN_q;
        lbN_d = lbN_q;
        dOut_d = dOut_q;
        dOe_d = 16'h0000;
        retain_d = retain_q;
        lanes_d = lanes_q;
        tLoad = 1'b0;
        tValue = 12'h000;
        unique case (state_q)
            asx_pkg::ASX_POWERUP: begin
                // strap is sampled each cycle here, never at the reset edge itself
                strap_d = widthSelect;
                if (puLoad_q) begin
                    // first cycle after reset starts the full supply settling wait
                    tLoad = 1'b1;
                    tValue = 12'(asx_pkg::POWERUP_CYCLES);
                end else if (done) begin
                    state_d = asx_pkg::ASX_IDLE;
                    reqReady_d = 1'b1;
                end
            end
            asx_pkg::ASX_IDLE: begin
                reqReady_d = 1'b1;
                // address pins left alone between accesses to save memory power
                if (retainReq) begin
                    // deselect on both paths; retention flag rises the same edge
                    state_d = asx_pkg::ASX_RETAIN;
                    selN_d = 1'b1;
                    selH_d = 1'b0;
                    ubN_d = 1'b1;
                    lbN_d = 1'b1;
                    retain_d = 1'b1;
                    reqReady_d = 1'b0;
                end else if (reqValid) begin
                    reqReady_d = 1'b0;
                    addr_d = reqAddr[18:0];
                    a19_d = strap_q ? 1'b0 : reqAddr[19];
                    selN_d = 1'b0;
                    selH_d = 1'b1;
                    {ubN_d, lbN_d} = laneEnN(reqLaneEn, strap_q);
                    lanes_d = strap_q ? reqLaneEn : 2'b01;
                    tLoad = 1'b1;
                    if (reqWrite) begin
                        state_d = asx_pkg::ASX_WRITE;
                        tValue = 12'(asx_pkg::WRITE_PULSE_CYCLES);
                        weN_d = 1'b0;
                        dOut_d = reqWData;
                        dOe_d = {{8{strap_q}}, 8'hff};
                    end else begin
                        state_d = asx_pkg::ASX_READ;
                        tValue = 12'(asx_pkg::READ_CYCLE_CYCLES + 2);
                        oeN_d = 1'b0;
                    end
                end else begin
                    // standby while idle, address pins untouched
                    selN_d = 1'b1;
                    selH_d = 1'b0;
                end
            end
            asx_pkg::ASX_WRITE: begin
                weN_d = 1'b0;
                dOe_d = dOe_q;
                if (done) begin
                    // strobe and select_active_low rise as select_active_high falls; data drops with them, hold time is zero
                    weN_d = 1'b1;
                    dOe_d = 16'h0000;
                    selN_d = 1'b1;
                    selH_d = 1'b0;
                    state_d = asx_pkg::ASX_IDLE;
                    reqReady_d = 1'b1;
                end
            end
            asx_pkg::ASX_READ: begin
                oeN_d = 1'b0;
                // wait covers access time plus the two synchroniser stages
                if (done) begin
                    rspRData_d = 16'h0000;
                    if (lanes_q[0]) begin
                        rspRData_d[7:0] = dSync2_q[7:0];
                    end
                    if (lanes_q[1]) begin
                        rspRData_d[15:8] = dSync2_q[15:8];
                    end
                    rspValid_d = 1'b1;
                    oeN_d = 1'b1;
                    selN_d = 1'b1;
                    selH_d = 1'b0;
                    state_d = asx_pkg::ASX_IDLE;
                    reqReady_d = 1'b1;
                end
            end
            asx_pkg::ASX_RETAIN: begin
                if (!retainReq) begin
                    retain_d = 1'b0;
                    tLoad = 1'b1;
                    tValue = 12'(asx_pkg::READ_CYCLE_CYCLES);
                    state_d = asx_pkg::ASX_RECOVER;
                end
            end
            asx_pkg::ASX_RECOVER: begin
                if (done) begin
                    state_d = asx_pkg::ASX_IDLE;
                    reqReady_d = 1'b1;
                end
            end
            default: begin
                state_d = asx_pkg::ASX_IDLE;
            end
        endcase
    end

    // registers of the sequencer and pins
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= asx_pkg::ASX_POWERUP;
            strap_q    <= asx_pkg::WIDTH_X16;
            reqReady_q <= 1'b0;
            rspValid_q <= 1'b0;
            rspRData_q <= 16'h0000;
            addr_q     <= 19'h00000;
            a19_q      <= 1'b0;
            selN_q     <= 1'b1;
            selH_q     <= 1'b0;
            weN_q      <= 1'b1;
            oeN_q      <= 1'b1;
            ubN_q      <= 1'b1;
            lbN_q      <= 1'b1;
            dOut_q     <= 16'h0000;
            dOe_q      <= 16'h0000;
            retain_q   <= 1'b0;
            lanes_q    <= 2'b00;
            dSync1_q   <= 16'h0000;
            dSync2_q   <= 16'h0000;
        end else begin
            state_q    <= state_d;
            strap_q    <= strap_d;
            reqReady_q <= reqReady_d;
            rspValid_q <= rspValid_d;
            rspRData_q <= rspRData_d;
            addr_q     <= addr_d;
            a19_q      <= a19_d;
            selN_q     <= selN_d;
            selH_q     <= selH_d;
            weN_q      <= weN_d;
            oeN_q      <= oeN_d;
            ubN_q      <= ubN_d;
            lbN_q      <= lbN_d;
            dOut_q     <= dOut_d;
            dOe_q      <= dOe_d;
            retain_q   <= retain_d;
            lanes_q    <= lanes_d;
            dSync1_q   <= sramDataIn;
            dSync2_q   <= dSync1_q;
        end
    end

    // one-shot that loads the power-up wait in the first cycle after reset
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            puLoad_q <= 1'b1;
        end else begin
            puLoad_q <= 1'b0;
        end
    end

    assign reqReady            = reqReady_q;
    assign rspValid            = rspValid_q;
    assign rspRData            = rspRData_q;
    assign inRetention         = retain_q;
    assign sramAddr            = addr_q;
    assign extra_address_bit   = a19_q;
    assign select_active_low   = selN_q;
    assign select_active_high  = selH_q;
    assign writeStrobe_n       = weN_q;
    assign outputStrobe_n      = oeN_q;
    assign upper_lane_enable_n = ubN_q;
    assign lower_lane_enable_n = lbN_q;
    assign sramDataOut         = dOut_q;
    assign sramDataOe          = dOe_q;

    // never drive data while the memory may be driving
    property p_no_contention;
        @(posedge core_clk) disable iff (!rst_n)
        (dOe_q != 16'h0000) |-> (weN_q == 1'b0 && oeN_q == 1'b1);
    endproperty
    a_no_contention: assert property (p_no_contention) else $error("data driven outside write");
    property p_write_seq;
        @(posedge core_clk) disable iff (!rst_n)
        $fell(weN_q) |-> (!selN_q && selH_q) ##1 !weN_q;
    endproperty
    a_write_seq: assert property (p_write_seq) else $error("write strobe without select");
    property p_read_seq;
        @(posedge core_clk) disable iff (!rst_n)
        !oeN_q |-> (!selN_q && selH_q && weN_q);
    endproperty
    a_read_seq: assert property (p_read_seq) else $error("read without select");
    property p_read_len;
        @(posedge core_clk) disable iff (!rst_n)
        $fell(oeN_q) |-> !oeN_q [*4] ##1 rspValid_q;
    endproperty
    a_read_len: assert property (p_read_len) else $error("read length wrong");
    property p_retain;
        @(posedge core_clk) disable iff (!rst_n)
        retain_q |-> (selN_q && !selH_q && ubN_q && lbN_q);
    endproperty
    a_retain: assert property (p_retain) else $error("retention without deselect");
    property p_recover;
        @(posedge core_clk) disable iff (!rst_n)
        $fell(retain_q) |-> !reqReady_q;
    endproperty
    a_recover: assert property (p_recover) else $error("no recovery after retention");
    property p_x8_lanes;
        @(posedge core_clk) disable iff (!rst_n)
        (!strap_q && !selN_q) |-> (dOe_q[15:8] == 8'h00);
    endproperty
    a_x8_lanes: assert property (p_x8_lanes) else $error("upper data used in x8");
    property p_standby;
        @(posedge core_clk) disable iff (!rst_n)
        (state_q == asx_pkg::ASX_IDLE) |-> selN_q;
    endproperty
    a_standby: assert property (p_standby) else $error("idle not deselected");
    property p_powerup;
        @(posedge core_clk) disable iff (!rst_n)
        (state_q == asx_pkg::ASX_POWERUP) |-> (selN_q && !reqReady_q);
    endproperty
    a_powerup: assert property (p_powerup) else $error("access before power-up wait");
endmodule

/* test/asx_sram_model.sv */
// behavioural model of the asynchronous 512K x16 / 1M x8 static memory
// assumes registered pin levels from the host controller; the memory has no clock
`timescale 1ns/10ps
module asx_sram_model (
    input  wire logic [18:0] sramAddr,
    input  wire logic        extra_address_bit,
    input  wire logic        select_active_low,
    input  wire logic        select_active_high,
    input  wire logic        writeStrobe_n,
    input  wire logic        outputStrobe_n,
    input  wire logic        upper_lane_enable_n,
    input  wire logic        lower_lane_enable_n,
    input  wire logic [15:0] sramDataOut,
    input  wire logic [15:0] sramDataOe,
    input  wire logic        widthSelect,
    output logic      [15:0] sramDataIn
);
    logic [15:0] mem16 [logic [18:0]]; // word store, 19-bit word address
    logic [7:0]  mem8 [logic [19:0]];  // byte store with the extra address bit
    logic        sel;                  // selected; otherwise standby
    logic [15:0] wd;                   // bus level, unknown where the host is not driving
    logic [15:0] word;                 // stored word at the address
    logic [19:0] bAddr;                // byte address in x8 mode
    assign sel = !select_active_low && select_active_high;
    assign wd = (sramDataOut & sramDataOe) | (16'hxxxx & ~sramDataOe);
    assign bAddr = {extra_address_bit, sramAddr};
    // store while a write is active, then drive reads; nothing happens when deselected
    always @(sel or writeStrobe_n or outputStrobe_n or sramAddr or bAddr or wd
             or upper_lane_enable_n or lower_lane_enable_n or widthSelect) begin
        word = mem16.exists(sramAddr) ? mem16[sramAddr] : 16'h0000;
        if (sel && !writeStrobe_n) begin
            if (!widthSelect) begin // lanes unused in x8
                mem8[bAddr] = wd[7:0];
            end else begin
                if (!lower_lane_enable_n) word[7:0] = wd[7:0];
                if (!upper_lane_enable_n) word[15:8] = wd[15:8];
                mem16[sramAddr] = word;
            end
        end
        // released pins never show the stored value, so a stray sample shows up
        sramDataIn = ~word;
        if (sel && writeStrobe_n && !outputStrobe_n) begin
            if (!widthSelect) begin
                sramDataIn[7:0] = mem8.exists(bAddr) ? mem8[bAddr] : 8'h00;
            end else begin
                if (!lower_lane_enable_n) sramDataIn[7:0] = word[7:0];
                if (!upper_lane_enable_n) sramDataIn[15:8] = word[15:8];
            end
        end
    end
endmodule

/* test/tb.sv */
// self-checking bench for the sram host controller with a memory model on the pins
// assumes the controller package is compiled first and a 10 MHz core clock
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin \
    cmp_count++; \
    if ((got) !== (ex)) begin \
        mismatches++; \
        $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
    end \
end
module tb;
    logic        core_clk    = 1'b0;       // 100 ns period
    logic        rst_n       = 1'b0;
    logic        reqValid    = 1'b0;
    logic        reqWrite    = 1'b0;
    logic [19:0] reqAddr     = 20'h00000;
    logic [1:0]  reqLaneEn   = 2'h0;
    logic [15:0] reqWData    = 16'h0000;
    logic        retainReq   = 1'b0;
    logic        widthSelect = 1'b1;       // strap, changed only under reset
    logic        reqReady, rspValid, inRetention, extra_address_bit;
    logic        select_active_low, select_active_high, writeStrobe_n, outputStrobe_n;
    logic        upper_lane_enable_n, lower_lane_enable_n;
    logic [18:0] sramAddr;
    logic [15:0] rspRData, sramDataOut, sramDataOe, sramDataIn;
    int          mismatches  = 0;
    int          cmp_count   = 0;
    logic [31:0] seed        = 32'h0000be16; // xorshift start
    logic [15:0] expQ [$];                   // expected read data, oldest first
    logic [15:0] ref16 [logic [19:0]];       // what the memory should hold
    logic [15:0] expHead;                    // note taken off the queue
    logic [19:0] curAddr     = 20'h00000;    // address of the access in flight
    logic [1:0]  curLane     = 2'h0;         // lanes of the access in flight

    always #50 core_clk = ~core_clk;

    asx_host_ctrl i_dut (
        .core_clk, .rst_n, .reqValid, .reqWrite, .reqAddr, .reqLaneEn, .reqWData,
        .retainReq, .widthSelect, .reqReady, .rspValid, .rspRData, .inRetention,
        .sramAddr, .extra_address_bit, .select_active_low, .select_active_high,
        .writeStrobe_n, .outputStrobe_n, .upper_lane_enable_n, .lower_lane_enable_n,
        .sramDataOut, .sramDataOe, .sramDataIn
    );
    asx_sram_model i_mem (
        .sramAddr, .extra_address_bit, .select_active_low, .select_active_high,
        .writeStrobe_n, .outputStrobe_n, .upper_lane_enable_n, .lower_lane_enable_n,
        .sramDataOut, .sramDataOe, .widthSelect, .sramDataIn
    );

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // step edges until ready or retention was high at an edge; bounded
    task automatic wait_for(input logic retention, input string nm);
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
            if (n > 100) begin
                mismatches++;
                $display("[FAIL] %s expected 1 seen timeout", nm);
                close_out();
            end
        end while ((retention ? inRetention : reqReady) !== 1'b1);
    endtask

    // one request; a write updates the reference and a read leaves its expected data
    task automatic access(input logic wr, input logic [19:0] a, input logic [1:0] ln,
                          input logic [15:0] d);
        logic [15:0] old;
        wait_for(1'b0, "ready");
        curAddr = a;
        curLane = widthSelect ? ln : 2'b11;
        reqValid <= 1'b1;
        reqWrite <= wr;
        reqAddr <= a;
        reqLaneEn <= ln;
        reqWData <= d;
        old = ref16.exists(a) ? ref16[a] : 16'h0000;
        if (wr) begin
            if (ln[0] || !widthSelect) old[7:0] = d[7:0];
            if (ln[1] && widthSelect) old[15:8] = d[15:8];
            ref16[a] = old;
        end else begin
            expQ.push_back(widthSelect ? old & {{8{ln[1]}}, {8{ln[0]}}} : {8'h00, old[7:0]});
        end
        @(posedge core_clk);
        reqValid <= 1'b0;
    endtask

    // result checker plus pin watch; pin values are the ones held before the edge
    always @(posedge core_clk) begin
        if (rst_n && rspValid === 1'b1) begin
            if (expQ.size() == 0) begin
                `CHK("spare response", 1'b0, 1'b1)
            end else begin
                expHead = expQ.pop_front();
                `CHK("read data", expHead, rspRData)
            end
        end
        if (rst_n && (writeStrobe_n === 1'b0 || outputStrobe_n === 1'b0)) begin
            `CHK("selects", 2'b01, {select_active_low, select_active_high})
            `CHK("lanes", ~curLane, {upper_lane_enable_n, lower_lane_enable_n})
            `CHK("address", {curAddr[19] & ~widthSelect, curAddr[18:0]},
                 {extra_address_bit & ~widthSelect, sramAddr})
            `CHK("strobes", 1'b1, writeStrobe_n ^ outputStrobe_n)
        end
        if (rst_n && outputStrobe_n === 1'b0) `CHK("read drive", 16'h0000, sramDataOe)
        if (rst_n && reqReady === 1'b1) begin
            `CHK("idle deselect", 2'b10, {select_active_low, select_active_high})
        end
        if (rst_n && inRetention === 1'b1) begin
            `CHK("retention", 1'b1, select_active_low | !select_active_high |
                 (upper_lane_enable_n & lower_lane_enable_n))
        end
    end

    initial begin
        logic [31:0] r;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (asx_pkg::POWERUP_CYCLES) @(posedge core_clk);
        `CHK("powerup wait", 1'b0, reqReady)
        // address boundaries, then random mix of back-to-back reads and writes
        access(1'b1, 20'h00000, 2'b11, 16'ha55a);
        access(1'b1, 20'h7ffff, 2'b11, 16'h3cc3);
        access(1'b0, 20'h7ffff, 2'b11, 16'h0000);
        access(1'b0, 20'h00000, 2'b11, 16'h0000);
        for (int k = 0; k < 40; k++) begin
            r = xs();
            access(r[8], {1'b0, r[4], 14'h0000, r[3:0]}, (r[6:5] == 2'b00) ? 2'b11 : r[6:5],
                   r[31:16]);
        end
        // retention, a refused request inside it, then recovery and read-back
        wait_for(1'b0, "ready");
        retainReq <= 1'b1;
        wait_for(1'b1, "retention entry");
        // a write that would spoil the read-back if it were taken
        reqValid <= 1'b1;
        reqWrite <= 1'b1;
        reqAddr <= 20'h7ffff;
        reqLaneEn <= 2'b11;
        reqWData <= 16'h0ff0;
        @(posedge core_clk);
        reqValid <= 1'b0;
        repeat (4) @(posedge core_clk);
        retainReq <= 1'b0;
        repeat (3) @(posedge core_clk);
        `CHK("recovery wait", 1'b0, reqReady)
        access(1'b0, 20'h7ffff, 2'b11, 16'h0000);
        // second reset into byte-wide mode; the extra address bit selects a new byte
        wait_for(1'b0, "ready");
        rst_n <= 1'b0;
        widthSelect <= 1'b0;
        ref16.delete();
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (asx_pkg::POWERUP_CYCLES) @(posedge core_clk);
        `CHK("powerup wait", 1'b0, reqReady)
        for (int k = 0; k < 24; k++) begin
            r = xs();
            access(r[8], {r[4], 15'h0000, r[3:0]}, 2'b01, r[31:16]);
        end
        wait_for(1'b0, "ready");
        repeat (8) @(posedge core_clk);
        `CHK("responses owed", 0, expQ.size())
        close_out();
    end
endmodule
